// file: hw/csu_pkg.sv
// package: constants and carrier types for the core storage unit cycle block
package csu_pkg;
	localparam int DATA_W      = 64;
	localparam int PAR_W       = 8;
	localparam int WORD_W      = DATA_W + PAR_W;
	localparam int BULK_WORDS  = 262144;
	localparam int ADDR_W      = 18;
	localparam int G1_W        = 1;
	localparam int G3_W        = 3;
	localparam int G4_W        = 4;
	localparam int ROW_W       = ADDR_W - G1_W - G3_W - G4_W;
	localparam int MAX_UNITS   = 4;
	localparam int UNIT_SEL_W  = 2;
	localparam int ARRAY_WORDS = 16;
	localparam int ARRAY_AW    = 4;
	localparam int NUM_SYS     = 2;
	localparam logic [UNIT_SEL_W-1:0] WAY2_MASK = 2'h1;
	localparam logic [UNIT_SEL_W-1:0] WAY4_MASK = 2'h3;

	typedef enum logic {CSU_FETCH, CSU_STORE} csu_op_type;

	typedef struct packed {
		csu_op_type              op;
		logic [ADDR_W-1:0]       addr;
		logic [WORD_W-1:0]       data;
	} csu_req_type;
endpackage : csu_pkg

// file: hw/csu_unit.sv
// one interleaved core unit: latched address, data latch, read half then write half
`timescale 1ns/100ps
module csu_unit (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// request
	input  wire logic                        start,
	input  wire csu_pkg::csu_req_type        req,
	// status and fetch data
	output logic                             busy,
	output logic                             done,
	output logic [csu_pkg::WORD_W-1:0]       fetch_data
);
	typedef enum logic [1:0] {CSU_IDLE, CSU_READ, CSU_WRITE} csu_state_type;

	csu_state_type                         state_ff, nxt_state;
	logic [csu_pkg::ADDR_W-1:0]            storage_address_latch_ff;
	logic [csu_pkg::WORD_W-1:0]            memory_data_latch_ff;
	logic                                  store_ff;
	logic [csu_pkg::WORD_W-1:0]            core_ff [csu_pkg::ARRAY_WORDS];
	logic [csu_pkg::ARRAY_AW-1:0]          word_idx;
	logic [csu_pkg::ARRAY_WORDS-1:0]       word_sel;

	// decode the latched address in groups of 1, 3 and 4 bits; the 4-bit group is masked off for all 16 words, so only the 1- and 3-bit groups select
	function automatic logic [csu_pkg::ARRAY_WORDS-1:0] grp_dec(
		input logic [csu_pkg::ADDR_W-1:0] a);
		logic [1:0] d1;
		logic [7:0] d3;
		logic [15:0] d4;
		logic [csu_pkg::ARRAY_WORDS-1:0] r;
		d1 = 2'h1 << a[0];
		d3 = 8'h01 << a[3:1];
		d4 = 16'h0001 << a[7:4];
		r = '0;
		for (int i = 0; i < csu_pkg::ARRAY_WORDS; i++) begin
			r[i] = d1[i % 2] & d3[(i / 2) % 8] & (d4[i / 16] | (i < 16));
		end
		return r;
	endfunction : grp_dec

	assign word_sel   = grp_dec(storage_address_latch_ff); // RL9 RL5
	assign word_idx   = storage_address_latch_ff[csu_pkg::ARRAY_AW-1:0]; // RL10
	assign busy       = (state_ff != CSU_IDLE);
	assign done       = (state_ff == CSU_WRITE);
	assign fetch_data = memory_data_latch_ff; // RL7

	// sequence: read half then write half
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			CSU_IDLE:  if (start) nxt_state = CSU_READ;
			CSU_READ:  nxt_state = CSU_WRITE; // RL13
			CSU_WRITE: nxt_state = CSU_IDLE;
			// the fourth state code is unused; fall back to idle if it ever appears
			default:   nxt_state = CSU_IDLE;
		endcase
	end

	// address and op latched once; requester may drop them after this edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff                 <= CSU_IDLE;
			storage_address_latch_ff <= '0;
			store_ff                 <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == CSU_IDLE && start) begin
				storage_address_latch_ff <= req.addr; // RL4
				store_ff                 <= (req.op == csu_pkg::CSU_STORE);
			end
		end
	end

	// data latch: read-out word on a fetch; on a store, store data loaded at the start edge, before the read half
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memory_data_latch_ff <= '0;
		end else if (state_ff == CSU_IDLE && start && req.op == csu_pkg::CSU_STORE) begin
			memory_data_latch_ff <= req.data; // RL6 RL13
		end else if (state_ff == CSU_READ && !store_ff) begin
			memory_data_latch_ff <= core_ff[word_idx]; // RL1
		end
	end

	// write half restores a fetch or writes store data; one selected word only
	genvar g;
	generate
		for (g = 0; g < csu_pkg::ARRAY_WORDS; g++) begin : g_word
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					core_ff[g] <= '0;
				end else if (state_ff == CSU_WRITE && word_sel[g]) begin
					core_ff[g] <= memory_data_latch_ff; // RL8 RL6
				end
			end
		end
	endgenerate

	// the write half must hit the word the latch pointed at
	a_write_target: assert property (@(posedge clk) disable iff (!rst_n) // RL5
		(state_ff == CSU_WRITE) |-> $onehot(word_sel) && word_sel[word_idx])
		else $error("write half does not select exactly the latched word");
	a_addr_hold: assert property (@(posedge clk) disable iff (!rst_n) // RL4
		(state_ff == CSU_READ) |=> $stable(storage_address_latch_ff))
		else $error("address latch changed inside a cycle");
	a_restore_data: assert property (@(posedge clk) disable iff (!rst_n) // RL8
		(state_ff == CSU_WRITE) |=> core_ff[$past(word_idx)] == $past(memory_data_latch_ff))
		else $error("addressed word not rewritten from data latch");
	a_cycle_len: assert property (@(posedge clk) disable iff (!rst_n) // RL13
		(state_ff == CSU_IDLE && start) |=> (state_ff == CSU_READ) ##1 (state_ff == CSU_WRITE)
		##1 (state_ff == CSU_IDLE))
		else $error("access cycle not read half then write half");
	a_store_latch: assert property (@(posedge clk) disable iff (!rst_n) // RL6
		(state_ff == CSU_IDLE && start && req.op == csu_pkg::CSU_STORE)
		|=> ##1 memory_data_latch_ff == $past(req.data, 2))
		else $error("store data not in data latch before write half");
endmodule : csu_unit

// file: hw/csu_storage.sv
// top: interleaved core storage units with two-system sharing
`timescale 1ns/100ps
// How it works
// RL1: words move as 64 data plus 8 parity
// RL2: two-way or four-way unit interleave
// RL3: successive words go to units in turn
// RL4: address latched once and held whole cycle
// RL5: latched address selects exactly one word
// RL6: store data replaces read-out word in latch
// RL7: fetch drives data latch contents out
// RL8: fetch rewrites addressed word from latch
// RL9: bulk decode in 1, 3, 4 bit groups
// RL10: bulk unit holds up to 262144 words; each unit here holds only 16
// RL11: pairs same size, pairs take low addresses
// RL12: two systems share the same storage
// RL13: read half then write half, latch loaded first
module csu_storage (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// configuration straps
	input  wire logic                        four_way,
	// request from each system
	input  wire logic [csu_pkg::NUM_SYS-1:0] req_valid,
	input  wire csu_pkg::csu_req_type        req_sys0,
	input  wire csu_pkg::csu_req_type        req_sys1,
	output logic      [csu_pkg::NUM_SYS-1:0] req_ready,
	// fetch data back to the requester
	output logic      [csu_pkg::NUM_SYS-1:0] fetch_valid,
	output logic [csu_pkg::WORD_W-1:0]       fetch_data
);
	logic                                    rst_meta_ff, rst_n_ff;
	logic [csu_pkg::UNIT_SEL_W-1:0]          unit_mask;
	logic                                    grant1;
	csu_pkg::csu_req_type                    sel_req, unit_req;
	logic                                    sel_valid;
	logic [csu_pkg::UNIT_SEL_W-1:0]          sel_unit;
	logic [csu_pkg::MAX_UNITS-1:0]           unit_busy, unit_done, unit_start;
	logic [csu_pkg::WORD_W-1:0]              unit_data [csu_pkg::MAX_UNITS];
	logic [csu_pkg::NUM_SYS-1:0]             owner_ff [csu_pkg::MAX_UNITS];
	logic [csu_pkg::MAX_UNITS-1:0]           fetch_ff;
	logic                                    last_grant_ff;
	logic [csu_pkg::NUM_SYS-1:0]             nxt_fetch_valid, fetch_valid_ff;
	logic [csu_pkg::WORD_W-1:0]              nxt_fetch_data, fetch_data_ff;

	// reset released through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// low address bits pick the unit so successive words alternate
	assign unit_mask = four_way ? csu_pkg::WAY4_MASK : csu_pkg::WAY2_MASK; // RL2
	assign grant1    = req_valid[1] && (!req_valid[0] || !last_grant_ff); // RL12
	assign sel_req   = grant1 ? req_sys1 : req_sys0;
	assign sel_valid = |req_valid;
	assign sel_unit  = sel_req.addr[csu_pkg::UNIT_SEL_W-1:0] & unit_mask; // RL3 RL11

	// the unit sees the word address with the interleave bits removed
	always_comb begin
		unit_req      = sel_req;
		unit_req.addr = four_way ? (sel_req.addr >> 2) : (sel_req.addr >> 1);
	end

	// start only the idle target unit; others may still be mid-cycle
	genvar u;
	generate
		for (u = 0; u < csu_pkg::MAX_UNITS; u++) begin : g_unit
			assign unit_start[u] = sel_valid && !unit_busy[u]
				&& (sel_unit == csu_pkg::UNIT_SEL_W'(u)); // RL3
			csu_unit u_core (
				.clk        (clk),
				.rst_n      (rst_n_ff),
				.start      (unit_start[u]),
				.req        (unit_req),
				.busy       (unit_busy[u]),
				.done       (unit_done[u]),
				.fetch_data (unit_data[u])
			);
			// remember who asked and whether data returns
			always_ff @(posedge clk or negedge rst_n_ff) begin
				if (!rst_n_ff) begin
					owner_ff[u] <= '0;
					fetch_ff[u] <= 1'b0;
				end else if (unit_start[u]) begin
					owner_ff[u] <= grant1 ? 2'h2 : 2'h1;
					fetch_ff[u] <= (sel_req.op == csu_pkg::CSU_FETCH);
				end
			end
			// a unit is busy for its read half and its write half, then free again
			a_unit_busy: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL13
				unit_start[u] |=> unit_busy[u] ##1 unit_busy[u] ##1 !unit_busy[u])
				else $error("unit busy time is not two halves");
			// the same unit cannot take another word inside its own cycle
			a_unit_spacing: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL3
				unit_start[u] |=> !unit_start[u] ##1 !unit_start[u])
				else $error("unit restarted inside its own cycle");
			// the write half that restores or stores comes two edges after the start
			a_unit_done: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL8
				unit_start[u] |-> ##2 unit_done[u])
				else $error("unit write half not reached on time");
			// a finishing fetch hands its data latch word to the return register
			a_return_data: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL7
				(unit_done[u] && fetch_ff[u]) |=> fetch_data == $past(unit_data[u]))
				else $error("returned word is not the unit data latch");
		end
	endgenerate

	// ready goes to the granted system when its unit is free
	assign req_ready[0] = !grant1 && req_valid[0] && (|unit_start);
	assign req_ready[1] = grant1 && (|unit_start);

	// round-robin between systems so neither is starved
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			last_grant_ff <= 1'b0;
		end else if (|unit_start) begin
			last_grant_ff <= grant1;
		end
	end

	// return path: at most one unit finishes per cycle since starts are serial
	always_comb begin
		nxt_fetch_valid = '0;
		nxt_fetch_data  = fetch_data_ff;
		for (int i = 0; i < csu_pkg::MAX_UNITS; i++) begin
			if (unit_done[i] && fetch_ff[i]) begin
				nxt_fetch_valid = owner_ff[i];
				nxt_fetch_data  = unit_data[i]; // RL7 RL1
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			fetch_valid_ff <= '0;
			fetch_data_ff  <= '0;
		end else begin
			fetch_valid_ff <= nxt_fetch_valid;
			fetch_data_ff  <= nxt_fetch_data;
		end
	end

	assign fetch_valid = fetch_valid_ff;
	assign fetch_data  = fetch_data_ff;

	a_one_start: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL3
		$onehot0(unit_start))
		else $error("more than one unit started");
	a_unit_route: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL2
		(|unit_start && !four_way) |-> (unit_start[2] == 1'b0 && unit_start[3] == 1'b0))
		else $error("two-way mode used an upper unit");
	a_share_grant: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL12
		!(req_ready[0] && req_ready[1]))
		else $error("both systems granted at once");
	a_fetch_time: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL7
		(|unit_start && sel_req.op == csu_pkg::CSU_FETCH) |-> ##3 (|fetch_valid))
		else $error("fetch data not returned three cycles after start");
	// the word goes back to the system that was granted at the start
	a_return_owner: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL12
		(|unit_start && sel_req.op == csu_pkg::CSU_FETCH) |-> ##3 (fetch_valid == $past(req_ready, 3)))
		else $error("fetch returned to the wrong system");
	// no return pulse without a unit finishing a fetch one cycle before
	a_no_ghost: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL7
		(|fetch_valid) |-> $past(|(unit_done & fetch_ff)))
		else $error("fetch return without a finished fetch");
	// ready only answers a system that is asking
	a_ready_asked: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL12
		(req_ready & ~req_valid) == '0)
		else $error("ready given to a system that did not ask");
	// the upper units stay idle in two-way mode; the strap only moves in reset
	a_upper_idle: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL2
		!four_way |-> (unit_busy[2] == 1'b0 && unit_busy[3] == 1'b0))
		else $error("upper unit busy in two-way mode");

	// a held request is taken within a few unit cycles, so neither system starves
	genvar s;
	generate
		for (s = 0; s < csu_pkg::NUM_SYS; s++) begin : g_sys
			a_no_starve: assert property (@(posedge clk) disable iff (!rst_n_ff) // RL12
				(req_valid[s] && !req_ready[s]) |-> ##[1:8] req_ready[s])
				else $error("held request not taken in time");
		end
	endgenerate
endmodule : csu_storage

// file: verification/csu_req_model.sv
// requester model: one system's request port, each request held until taken
`timescale 1ns/100ps
module csu_req_model (
	// clock
	input  wire logic            clk,
	// handshake
	input  wire logic            ready,
	output logic                 valid,
	output csu_pkg::csu_req_type req
);
	csu_pkg::csu_req_type q[$];
	csu_pkg::csu_req_type req_q = '0;
	logic                 valid_q = 1'b0;
	int                   seed = 97765;
	int                   gap = 0;
	// one process owns the handshake; the ports only mirror it
	assign valid = valid_q;
	assign req   = req_q;
	function automatic bit is_idle();
		return !valid_q && q.size() == 0;
	endfunction : is_idle
	task automatic push(input csu_pkg::csu_req_type r);
		q.push_back(r);
	endtask : push
	// random gaps make the requester slow at times; contents flip once released
	always @(posedge clk) begin
		if (valid_q && ready) begin
			valid_q <= 1'b0;
			req_q <= ~req_q;
		end else if (!valid_q && q.size() != 0) begin
			if (gap == 0) begin
				req_q <= q.pop_front();
				valid_q <= 1'b1;
				gap = ($random(seed) & 3) % 3;
			end else begin
				gap = gap - 1;
			end
		end
	end
endmodule : csu_req_model

// file: verification/testbench.sv
// self-checking bench: shared interleaved storage driven from two systems
`timescale 1ns/100ps
module testbench;
	typedef struct {logic [1:0] sys; int due; bit chk; logic [71:0] w;} csu_exp_type;
	logic                       clk, rstn, four_way;
	logic [1:0]                 req_valid, req_ready, fetch_valid;
	csu_pkg::csu_req_type       req_sys0, req_sys1;
	logic [csu_pkg::WORD_W-1:0] fetch_data;
	logic [71:0]                mem[int];
	csu_exp_type                expq[$];
	int                         error_cnt = 0, n_tests = 0, cyc = 0, seed = 97765;

	csu_storage uut (.clk(clk), .rstn(rstn), .four_way(four_way), .req_valid(req_valid),
		.req_sys0(req_sys0), .req_sys1(req_sys1), .req_ready(req_ready),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data));
	csu_req_model u0 (.clk(clk), .ready(req_ready[0]), .valid(req_valid[0]), .req(req_sys0));
	csu_req_model u1 (.clk(clk), .ready(req_ready[1]), .valid(req_valid[1]), .req(req_sys1));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
		n_tests++;
		if (exp !== got) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	// only the unit bits and the 16-word array index reach the core; the rest alias
	function automatic int key(input logic [17:0] a);
		return four_way ? int'(a[5:0]) : int'(a[4:0]);
	endfunction : key

	// driver side: note each request at the falling edge before the rising edge that takes it
	always @(negedge clk) if (rstn) begin
		for (int s = 0; s < 2; s++) if (req_valid[s] && req_ready[s]) begin
			automatic csu_pkg::csu_req_type r = s ? req_sys1 : req_sys0;
			automatic int k = key(r.addr);
			automatic logic [71:0] w = mem.exists(k) ? mem[k] : '0;
			if (r.op == csu_pkg::CSU_STORE) mem[k] = r.data;
			else expq.push_back('{2'(1 << s), cyc + 3, mem.exists(k), w});
		end
	end

	// watcher: take the oldest note whenever a fetch returns
	always @(negedge clk) if (rstn) begin
		if (req_ready !== 2'h0) check("ready_onehot", 1, $onehot0(req_ready));
		if (fetch_valid !== 2'h0) begin
			if (expq.size() == 0) check("fetch_valid", 0, fetch_valid);
			else begin
				automatic csu_exp_type e = expq.pop_front();
				check("fetch_valid", e.sys, fetch_valid);
				check("fetch_cycle", e.due, cyc);
				if (e.chk) check("fetch_data", e.w, fetch_data);
			end
		end
	end

	task automatic send(input int s, input csu_pkg::csu_op_type op, input logic [17:0] a);
		automatic csu_pkg::csu_req_type r;
		r.op = op;
		r.addr = a;
		r.data = 72'({$random(seed), $random(seed), $random(seed)});
		if (s == 0) u0.push(r);
		else u1.push(r);
	endtask : send

	task automatic wait_idle(input string name);
		int n;
		for (n = 0; n < 4000 && !(u0.is_idle() && u1.is_idle() && expq.size() == 0); n++)
			@(posedge clk);
		if (n == 4000) begin
			error_cnt++;
			$display("test %s timed out", name);
			stop_test();
		end else begin
			$display("test %s done", name);
		end
	endtask : wait_idle

	task automatic do_reset(input logic fw);
		rstn <= 1'b0;
		four_way <= fw;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		mem.delete();
	endtask : do_reset

	initial begin
		rstn = 1'b0;
		four_way = 1'b0;
		for (int m = 0; m < 2; m++) begin
			do_reset(m[0]);
			// successive words from one system, read back twice by the other
			for (int i = 0; i < 16; i++) send(m, csu_pkg::CSU_STORE, 18'(i));
			wait_idle("fill");
			for (int i = 0; i < 32; i++) send(1 - m, csu_pkg::CSU_FETCH, 18'(i % 16));
			wait_idle("readback");
			// both systems at once, full-width random addresses that alias
			for (int i = 0; i < 120; i++)
				send(i % 2, csu_pkg::csu_op_type'($random(seed) & 1), 18'($random(seed)));
			wait_idle(m ? "four_way_mix" : "two_way_mix");
		end
		stop_test();
	end
endmodule : testbench
